// ### rtl/wmc_io_hold.sv
/*
 * Port latch: captures port direction and level at wait entry and
 * drives the captured copy out while wait lasts.
 * Assumes one clock and a synchronous active-high reset.
 */
module wmc_io_hold
   import wmc_pkg::*;
(
   input  wire logic             sys_clk,  // system clock
   input  wire logic             rst,      // sync reset
   input  wire logic             capture,  // one-cycle entry pulse
   input  wire logic             hold,     // wait in progress
   input  wire wmc_pkg::wmc_io_t portOut,  // live port level
   input  wire wmc_pkg::wmc_io_t portDir,  // live port direction
   output wmc_pkg::wmc_io_t      heldOut,  // port level to pad
   output wmc_pkg::wmc_io_t      heldDir   // direction to pad
);
   wmc_io_t outSave_ff;
   wmc_io_t dirSave_ff;
   wmc_io_t nxt_outSave;
   wmc_io_t nxt_dirSave;
   wmc_io_t heldOut_ff;
   wmc_io_t heldDir_ff;
   wmc_io_t nxt_heldOut;
   wmc_io_t nxt_heldDir;

   always_comb begin
      nxt_outSave = capture ? portOut : outSave_ff;
      nxt_dirSave = capture ? portDir : dirSave_ff;
      // registered output: one cycle of latency on live ports too
      nxt_heldOut = (hold && !capture) ? outSave_ff : portOut; // RQ7
      nxt_heldDir = (hold && !capture) ? dirSave_ff : portDir; // RQ7
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         outSave_ff <= 8'h00;
         dirSave_ff <= 8'h00;
         heldOut_ff <= 8'h00;
         heldDir_ff <= 8'h00;
      end else begin
         outSave_ff <= nxt_outSave;
         dirSave_ff <= nxt_dirSave;
         heldOut_ff <= nxt_heldOut;
         heldDir_ff <= nxt_heldDir;
      end
   end

   assign heldOut = heldOut_ff;
   assign heldDir = heldDir_ff;
endmodule

// ### rtl/wmc_params.svh
/*
 * Constants of the wait mode controller: register offsets, field
 * positions, reset values, counts and wake source indices.
 * Assumes inclusion by the package and the design modules; holds only
 * definitions.
 */
// How it works
// RQ1: halt instruction or wait request bit enters wait
// RQ2: software clears osc-stop irq enable first
// RQ3: osc-stop irq enabled keeps CPU clock running
// RQ4: software clears flash rewrite, low-current read first
// RQ5: wait bit needs I=0, halt needs I=1
// RQ6: low-power bit cuts power in low-speed modes
// RQ7: I/O ports hold direction and level
// RQ8: only reset or enabled interrupt exits wait
// RQ9: clocks running: all but A/D interrupt wake
// RQ10: clocks stopped: only external or onchip-osc sources wake
// RQ11: serial wakes; stopped clocks need external clocking
// RQ12: software avoids wait during A/D conversion
// RQ13: timer A: unfiltered event count or slow sources
// RQ14: timer B: timer A on onchip osc, cascaded
// RQ15: timer E: stopped clocks need real-time-clock mode
// RQ16: ext lines 0,1,3 wake only unfiltered
// RQ17: software avoids SSU/I2C, timer C, osc-stop wakeups
// RQ18: key, voltage monitors, comparators always wake
// RQ19: wait stops CPU clock, oscillators keep running
// RQ20: clock-stop bit gates divided peripheral clocks
// RQ21: wake ungates CPU clock before interrupt processing
`ifndef WMC_PARAMS_SVH
`define WMC_PARAMS_SVH

`define WMC_ADDR_W        4
`define WMC_DATA_W        8
`define WMC_ADDR_CTRL     4'h0
`define WMC_ADDR_CFG      4'h1
`define WMC_ADDR_WAKEEN   4'h2
`define WMC_ADDR_WAKEEN2  4'h3
`define WMC_ADDR_STATUS   4'h4
// ctrl register
`define WMC_CTRL_WAITREQ  0
`define WMC_CTRL_PCSTOP   1
`define WMC_CTRL_OSCIRQ   2
`define WMC_CTRL_LOWPWR   3
`define WMC_CTRL_RST      8'h00
// cfg register: peripheral modes that matter while clocks are stopped, plus the low-speed mode bit for low power
`define WMC_CFG_SEREXT    0
`define WMC_CFG_TAEVT     1
`define WMC_CFG_TAFILT    2
`define WMC_CFG_TASLOW    3
`define WMC_CFG_TBCASC    4
`define WMC_CFG_TERTC     5
`define WMC_CFG_INTFILT   6
`define WMC_CFG_LOWSPD    7
`define WMC_CFG_RST       8'h00
`define WMC_WAKEEN_RST    8'h00
`define WMC_NUM_SRC       16
`define WMC_NUM_IO        8
`define WMC_NUM_PCLK      5
// wake source indices
`define WMC_SRC_SERIAL    0
`define WMC_SRC_SSU       1
`define WMC_SRC_KEY       2
`define WMC_SRC_ADC       3
`define WMC_SRC_TMRA      4
`define WMC_SRC_TMRB      5
`define WMC_SRC_TMRC      6
`define WMC_SRC_TMRE      7
`define WMC_SRC_EXT_IRQ_LINE_0      8
`define WMC_SRC_EXT_IRQ_LINE_1      9
`define WMC_SRC_EXT_IRQ_LINE_3      10
`define WMC_SRC_VMON1     11
`define WMC_SRC_VMON2     12
`define WMC_SRC_OSCSTOP   13
`define WMC_SRC_CMP1      14
`define WMC_SRC_CMP2      15

`endif

// ### rtl/wmc_pkg.sv
/*
 * Types shared by the wait mode controller.
 * Assumes the params header sits beside it on the include path.
 */
`include "wmc_params.svh"
package wmc_pkg;
   typedef enum logic [1:0] {WMC_RUN, WMC_WAIT, WMC_WAKE} wmc_state_e;
   typedef logic [`WMC_DATA_W-1:0] wmc_data_t;
   typedef logic [`WMC_ADDR_W-1:0] wmc_addr_t;
   typedef logic [`WMC_NUM_SRC-1:0] wmc_src_t;
   typedef logic [`WMC_NUM_IO-1:0] wmc_io_t;
endpackage

// ### rtl/wmc_wait_ctrl.sv
/*
 * Wait mode controller: entry by halt or wait request bit, clock
 * gating of CPU and divided peripheral clocks, wake-source filtering
 * by the peripheral-clock-stop setting, port hold during wait.
 * Assumes all inputs synchronous to sys_clk; the clock generator
 * consumes the gate enables; software respects the entry conditions.
 */
`include "wmc_params.svh"
module wmc_wait_ctrl
   import wmc_pkg::*;
(
   input  wire logic             sys_clk,      // 250 MHz clock
   input  wire logic             rst,          // sync reset, high
   input  wire wmc_pkg::wmc_addr_t regAddr,    // register address
   input  wire wmc_pkg::wmc_data_t regWdata,   // write data
   input  wire logic             regWr,        // write strobe
   input  wire logic             regRd,        // read strobe
   output wmc_pkg::wmc_data_t    regRdata,     // read data, next cycle
   input  wire logic             haltExec,     // CPU executes halt
   input  wire wmc_pkg::wmc_src_t irqReq,      // peripheral irq levels
   input  wire wmc_pkg::wmc_io_t portOut,      // live port level
   input  wire wmc_pkg::wmc_io_t portDir,      // live port direction
   output wmc_pkg::wmc_io_t      padOut,       // port level to pads
   output wmc_pkg::wmc_io_t      padDir,       // port direction to pads
   output logic      cpuClkEn,                 // CPU clock gate enable
   output logic      [`WMC_NUM_PCLK-1:0] pclkEn, // f1,f2,f4,f8,f32 enables
   output logic      lowPowerOn,               // internal low power
   output logic      inWait,                   // wait state level
   output logic      wakePulse                 // one-cycle wake event
);
   import wmc_pkg::*;

   wmc_state_e state_ff;
   wmc_state_e nxt_state;
   wmc_data_t  ctrl_ff;
   wmc_data_t  nxt_ctrl;
   wmc_data_t  cfg_ff;
   wmc_data_t  nxt_cfg;
   wmc_src_t   wakeEn_ff;
   wmc_src_t   nxt_wakeEn;
   wmc_data_t  rdata_ff;
   wmc_data_t  nxt_rdata;
   wmc_src_t   wakeOk;
   logic       enterReq;
   logic       waking;
   logic       pcStop;
   logic       capture;
   logic       cpuClkEn_ff;
   logic       nxt_cpuClkEn;
   logic [`WMC_NUM_PCLK-1:0] pclkEn_ff;
   logic [`WMC_NUM_PCLK-1:0] nxt_pclkEn;
   logic       lowPower_ff;
   logic       nxt_lowPower;
   logic       wakePulse_ff;
   logic       nxt_wakePulse;

   // qualifies each wake source against the clock-stop setting
   function automatic wmc_src_t usable(input logic stopped,
                                       input wmc_data_t cfg);
      wmc_src_t u;
      u = 16'hFFFF;
      u[`WMC_SRC_ADC] = 1'b0; // RQ9
      if (stopped) begin // RQ10
         u[`WMC_SRC_SERIAL]  = cfg[`WMC_CFG_SEREXT]; // RQ11
         u[`WMC_SRC_SSU]     = 1'b0;
         u[`WMC_SRC_TMRC]    = 1'b0;
         u[`WMC_SRC_OSCSTOP] = 1'b0;
         u[`WMC_SRC_TMRA]    = (cfg[`WMC_CFG_TAEVT] &&
                                !cfg[`WMC_CFG_TAFILT]) ||
                               cfg[`WMC_CFG_TASLOW]; // RQ13
         u[`WMC_SRC_TMRB]    = cfg[`WMC_CFG_TBCASC]; // RQ14
         u[`WMC_SRC_TMRE]    = cfg[`WMC_CFG_TERTC]; // RQ15
         u[`WMC_SRC_EXT_IRQ_LINE_0]    = !cfg[`WMC_CFG_INTFILT]; // RQ16
         u[`WMC_SRC_EXT_IRQ_LINE_1]    = !cfg[`WMC_CFG_INTFILT]; // RQ16
         u[`WMC_SRC_EXT_IRQ_LINE_3]    = !cfg[`WMC_CFG_INTFILT]; // RQ16
      end
      // key, voltage monitors and comparators stay usable always RQ18
      return u;
   endfunction

   assign pcStop   = ctrl_ff[`WMC_CTRL_PCSTOP];
   assign wakeOk   = usable(pcStop, cfg_ff);
   assign waking   = |(irqReq & wakeEn_ff & wakeOk); // RQ8
   assign enterReq = haltExec ||
                     (regWr && regAddr == `WMC_ADDR_CTRL &&
                      regWdata[`WMC_CTRL_WAITREQ]); // RQ1
   assign capture  = (state_ff == WMC_RUN) && enterReq;

   always_comb begin
      nxt_state = state_ff;
      nxt_wakePulse = 1'b0;
      case (state_ff)
         WMC_RUN: begin
            if (enterReq) begin
               nxt_state = WMC_WAIT; // RQ1
            end
         end
         WMC_WAIT: begin
            if (waking) begin
               nxt_state = WMC_WAKE; // RQ21
               nxt_wakePulse = 1'b1;
            end
         end
         WMC_WAKE: begin
            nxt_state = WMC_RUN;
         end
         default: begin
            nxt_state = WMC_RUN;
         end
      endcase
   end

   always_comb begin
      nxt_ctrl = ctrl_ff;
      nxt_cfg = cfg_ff;
      nxt_wakeEn = wakeEn_ff;
      nxt_rdata = 8'h00;
      if (regWr) begin
         case (regAddr)
            `WMC_ADDR_CTRL:    nxt_ctrl = regWdata;
            `WMC_ADDR_CFG:     nxt_cfg = regWdata;
            `WMC_ADDR_WAKEEN:  nxt_wakeEn[7:0] = regWdata;
            `WMC_ADDR_WAKEEN2: nxt_wakeEn[15:8] = regWdata;
            default: ;
         endcase
      end
      // wait request bit self-clears when wait ends RQ21
      if (nxt_state == WMC_WAKE) begin
         nxt_ctrl[`WMC_CTRL_WAITREQ] = 1'b0;
      end
      if (regRd) begin
         case (regAddr)
            `WMC_ADDR_CTRL:    nxt_rdata = ctrl_ff;
            `WMC_ADDR_CFG:     nxt_rdata = cfg_ff;
            `WMC_ADDR_WAKEEN:  nxt_rdata = wakeEn_ff[7:0];
            `WMC_ADDR_WAKEEN2: nxt_rdata = wakeEn_ff[15:8];
            `WMC_ADDR_STATUS:  nxt_rdata = {6'h00, cpuClkEn_ff,
                                            state_ff == WMC_WAIT};
            default:           nxt_rdata = 8'h00;
         endcase
      end
   end

   always_comb begin
      // osc-stop irq enabled: CPU clock stays on, no saving RQ3
      nxt_cpuClkEn = !(nxt_state == WMC_WAIT) ||
                     nxt_ctrl[`WMC_CTRL_OSCIRQ]; // RQ19
      nxt_pclkEn = (nxt_state == WMC_WAIT && nxt_ctrl[`WMC_CTRL_PCSTOP])
                   ? 5'h00 : 5'h1F; // RQ20
      nxt_lowPower = (nxt_state == WMC_WAIT) &&
                     nxt_ctrl[`WMC_CTRL_LOWPWR] &&
                     cfg_ff[`WMC_CFG_LOWSPD]; // RQ6
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_ff     <= WMC_RUN;
         ctrl_ff      <= `WMC_CTRL_RST;
         cfg_ff       <= `WMC_CFG_RST;
         wakeEn_ff    <= {`WMC_WAKEEN_RST, `WMC_WAKEEN_RST};
         rdata_ff     <= 8'h00;
         cpuClkEn_ff  <= 1'b1;
         pclkEn_ff    <= 5'h1F;
         lowPower_ff  <= 1'b0;
         wakePulse_ff <= 1'b0;
      end else begin
         state_ff     <= nxt_state;
         ctrl_ff      <= nxt_ctrl;
         cfg_ff       <= nxt_cfg;
         wakeEn_ff    <= nxt_wakeEn;
         rdata_ff     <= nxt_rdata;
         cpuClkEn_ff  <= nxt_cpuClkEn;
         pclkEn_ff    <= nxt_pclkEn;
         lowPower_ff  <= nxt_lowPower;
         wakePulse_ff <= nxt_wakePulse;
      end
   end

   wmc_io_hold u_io_hold (
      .sys_clk (sys_clk),
      .rst     (rst),
      .capture (capture),
      .hold    (state_ff == WMC_WAIT),
      .portOut (portOut),
      .portDir (portDir),
      .heldOut (padOut),
      .heldDir (padDir)
   ); // RQ7

   assign regRdata   = rdata_ff;
   assign cpuClkEn   = cpuClkEn_ff;
   assign pclkEn     = pclkEn_ff;
   assign lowPowerOn = lowPower_ff;
   assign inWait     = state_ff == WMC_WAIT;
   assign wakePulse  = wakePulse_ff;
endmodule

// ### tb/wmc_irq_model.sv
/* peripheral interrupt sources facing the wait mode controller.
   assumes the bench pulses setMask and clr for one cycle. */
module wmc_irq_model
   import wmc_pkg::*;
(
   input  wire logic              sys_clk, // clock
   input  wire logic              rst,     // sync reset
   input  wire wmc_pkg::wmc_src_t setMask, // sources to raise
   input  wire logic              clr,     // drop all old requests
   output wmc_pkg::wmc_src_t      irqReq   // request levels
);
   timeunit 1ns;
   timeprecision 100ps;
   // a flag stays up until software clears it, as a real source does
   always_ff @(posedge sys_clk) begin
      if (rst)
         irqReq <= '0;
      else
         irqReq <= (clr ? '0 : irqReq) | setMask;
   end
endmodule

// ### tb/wmc_wait_checker.sv
/* port-level properties of the wait mode controller.
   assumes a bind from the bench top and one clock domain. */
module wmc_wait_checker
   import wmc_pkg::*;
(
   input wire logic              sys_clk,    // clock
   input wire logic              rst,        // sync reset
   input wire logic              regRd,      // read strobe
   input wire wmc_pkg::wmc_data_t regRdata,  // read data
   input wire logic              haltExec,   // halt executed
   input wire wmc_pkg::wmc_src_t irqReq,     // irq levels
   input wire wmc_pkg::wmc_io_t  padOut,     // pad level
   input wire wmc_pkg::wmc_io_t  padDir,     // pad direction
   input wire logic              cpuClkEn,   // cpu clock gate
   input wire logic [4:0]        pclkEn,     // peripheral gates
   input wire logic              lowPowerOn, // low power
   input wire logic              inWait,     // in wait
   input wire logic              wakePulse   // wake event
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // wakePulse marks the wake cycle, where entry requests are ignored
   property p_entry; haltExec && !inWait && !wakePulse |=> inWait;
   endproperty
   a_entry: assert property (p_entry) else $error("halt ignored");
   property p_cpuclk; !cpuClkEn |-> inWait;
   endproperty
   a_cpuclk: assert property (p_cpuclk) else $error("cpu clk off");
   property p_pclk; pclkEn != 5'h1F |-> inWait && pclkEn == 5'h00;
   endproperty
   a_pclk: assert property (p_pclk) else $error("pclk gating");
   property p_wake;
      // leaving wait through reset carries no wake pulse
      $fell(inWait) && !$past(rst) |-> wakePulse && cpuClkEn &&
         pclkEn == 5'h1F;
   endproperty
   a_wake: assert property (p_wake) else $error("bad wake");
   property p_pulse; wakePulse |=> !wakePulse ##1 !wakePulse;
   endproperty
   a_pulse: assert property (p_pulse) else $error("long pulse");
   property p_hold;
      inWait && $past(inWait) |-> $stable(padOut) && $stable(padDir);
   endproperty
   a_hold: assert property (p_hold) else $error("pads moved");
   property p_noirq;
      inWait && (irqReq == 16'h0000 || irqReq == 16'h0008) |=> inWait;
   endproperty
   a_noirq: assert property (p_noirq) else $error("woke");
   property p_lowpwr; lowPowerOn |-> inWait;
   endproperty
   a_lowpwr: assert property (p_lowpwr) else $error("low power");
   property p_rdata; !$past(regRd) |-> regRdata == 8'h00;
   endproperty
   a_rdata: assert property (p_rdata) else $error("stray rdata");
endmodule

// ### tb/wmc_wait_ctrl_tb.sv
/* self-checking bench of the wait mode controller.
   assumes the params header on the include path. */
`include "wmc_params.svh"
module wmc_wait_ctrl_tb;
   import wmc_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   wmc_addr_t regAddr = '0;
   wmc_data_t regWdata = '0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic haltExec = 1'b0;
   wmc_io_t portOut = 8'hA5;
   wmc_io_t portDir = 8'h0F;
   wmc_src_t setMask = '0;
   logic clr = 1'b0;
   wmc_data_t regRdata;
   wmc_src_t irqReq;
   wmc_io_t padOut, padDir;
   logic cpuClkEn, lowPowerOn, inWait, wakePulse;
   logic [4:0] pclkEn;
   int n_mismatch = 0;
   int check_count = 0;
   localparam logic [7:0] CFG_T [13] = '{8'h00, 8'h01, 8'h02, 8'h06,
      8'h08, 8'h00, 8'h10, 8'h00, 8'h20, 8'h40, 8'h00, 8'h00, 8'h00};
   localparam logic [15:0] SRC_T [13] = '{16'h0001, 16'h0001, 16'h0010,
      16'h0010, 16'h0010, 16'h0020, 16'h0020, 16'h0080, 16'h0080,
      16'h0100, 16'h0400, 16'h8000, 16'h0040};
   // bit i: scenario i of the clock-stop table is expected to wake
   localparam logic [12:0] WAKE_T = 13'b0110101010110;

   always #2 sys_clk = ~sys_clk;

   wmc_wait_ctrl dut (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .haltExec(haltExec), .irqReq(irqReq),
      .portOut(portOut), .portDir(portDir), .padOut(padOut),
      .padDir(padDir), .cpuClkEn(cpuClkEn), .pclkEn(pclkEn),
      .lowPowerOn(lowPowerOn), .inWait(inWait), .wakePulse(wakePulse));
   wmc_irq_model src (.sys_clk(sys_clk), .rst(rst), .setMask(setMask),
      .clr(clr), .irqReq(irqReq));

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: seen %0h expected %0h", $time,
            seen, exp);
      end
   endtask
   task automatic wr(input wmc_addr_t a, input wmc_data_t d);
      @(posedge sys_clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge sys_clk);
      regWr <= 1'b0;
      #1;
   endtask
   task automatic rd(input wmc_addr_t a, input wmc_data_t exp);
      @(posedge sys_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge sys_clk);
      regRd <= 1'b0;
      #1;
      chk(regRdata, exp);
   endtask
   task automatic halt;
      @(posedge sys_clk);
      haltExec <= 1'b1;
      @(posedge sys_clk);
      haltExec <= 1'b0;
      #1;
   endtask
   // replaces all pending requests; the controller sees them one edge on
   task automatic irq(input wmc_src_t m);
      @(posedge sys_clk);
      setMask <= m;
      clr <= 1'b1;
      @(posedge sys_clk);
      setMask <= '0;
      clr <= 1'b0;
      @(posedge sys_clk);
      #1;
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic t_regs;
      rd(`WMC_ADDR_CTRL, 8'h00);
      rd(`WMC_ADDR_CFG, 8'h00);
      rd(`WMC_ADDR_WAKEEN2, 8'h00);
      rd(`WMC_ADDR_STATUS, 8'h02);
      wr(4'h5, 8'hFF);
      rd(4'h5, 8'h00);
      wr(`WMC_ADDR_STATUS, 8'hFF);
      rd(`WMC_ADDR_STATUS, 8'h02);
      $display("t_regs done");
   endtask
   // flash rewrite and low-current read are off at every entry
   // the on-chip oscillator is not the system clock here
   task automatic t_halt;
      wr(`WMC_ADDR_WAKEEN, 8'h0C);
      halt();
      chk(inWait, 1'b1);
      chk(cpuClkEn, 1'b0);
      chk(pclkEn, 5'h1F);
      portOut <= 8'h5A;
      portDir <= 8'hF0;
      irq(16'h0008);
      chk(inWait, 1'b1);
      chk({padDir, padOut}, 16'h0FA5);
      irq(16'h0004);
      chk({inWait, wakePulse, cpuClkEn}, 3'b011);
      @(posedge sys_clk);
      #1;
      chk({wakePulse, padOut}, 9'h05A);
      irq(16'h0000);
      $display("t_halt done");
   endtask
   task automatic t_osc;
      wr(`WMC_ADDR_WAKEEN2, 8'h08);
      wr(`WMC_ADDR_CTRL, 8'h05);
      chk({inWait, cpuClkEn}, 2'b11);
      irq(16'h0800);
      chk(inWait, 1'b0);
      rd(`WMC_ADDR_CTRL, 8'h04);
      irq(16'h0000);
      $display("t_osc done");
   endtask
   // no A/D, serial-unit or timer C wake is relied on
   task automatic t_stop;
      wr(`WMC_ADDR_WAKEEN, 8'hFF);
      wr(`WMC_ADDR_WAKEEN2, 8'hFF);
      for (int i = 0; i < 13; i++) begin
         wr(`WMC_ADDR_CFG, CFG_T[i]);
         wr(`WMC_ADDR_CTRL, 8'h03);
         chk(pclkEn, 5'h00);
         irq(SRC_T[i]);
         chk(inWait, !WAKE_T[i]);
         irq(16'h0004);
         irq(16'h0000);
      end
      $display("t_stop done");
   endtask
   task automatic t_low;
      wr(`WMC_ADDR_CFG, 8'h80);
      wr(`WMC_ADDR_CTRL, 8'h08);
      halt();
      chk(lowPowerOn, 1'b1);
      irq(16'h0080);
      chk({inWait, lowPowerOn}, 2'b00);
      irq(16'h0000);
      $display("t_low done");
   endtask
   // reset in the middle of wait is the other way out
   task automatic t_rst;
      halt();
      chk(lowPowerOn, 1'b1);
      @(posedge sys_clk);
      rst <= 1'b1;
      @(posedge sys_clk);
      rst <= 1'b0;
      #1;
      chk({inWait, cpuClkEn, lowPowerOn, pclkEn}, 8'h5F);
      rd(`WMC_ADDR_CTRL, 8'h00);
      $display("t_rst done");
   endtask

   initial begin
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      t_regs();
      t_halt();
      t_osc();
      t_stop();
      t_low();
      t_rst();
      results();
   end
   initial begin
      repeat (4000) @(posedge sys_clk);
      n_mismatch++;
      results();
   end
endmodule

bind wmc_wait_ctrl wmc_wait_checker chk_u (.sys_clk(sys_clk), .rst(rst),
   .regRd(regRd), .regRdata(regRdata), .haltExec(haltExec),
   .irqReq(irqReq), .padOut(padOut), .padDir(padDir),
   .cpuClkEn(cpuClkEn), .pclkEn(pclkEn), .lowPowerOn(lowPowerOn),
   .inWait(inWait), .wakePulse(wakePulse));
